// ===== hdl/pmt_pkg.sv
package pmt_pkg;
   localparam int unsigned PMT_AW = 8;
   localparam logic [PMT_AW-1:0] PMT_OFS_COUNT = 8'h00;
   localparam logic [PMT_AW-1:0] PMT_OFS_PERIOD = 8'h04;
   localparam logic [PMT_AW-1:0] PMT_OFS_CONTROL = 8'h08;
   localparam logic [PMT_AW-1:0] PMT_OFS_FLAGS = 8'h0c;
   localparam logic [PMT_AW-1:0] PMT_OFS_ENABLES = 8'h10;

   localparam logic [7:0] PMT_COUNT_RST = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST = 8'hff;
   localparam logic [6:0] PMT_CONTROL_RST = 7'h00;

   // control field layout; PMT_IRQ_BIT is the flags/enables bit, not a control bit
   localparam int unsigned PMT_PRE_LSB = 0;
   localparam int unsigned PMT_RUN_BIT = 2;
   localparam int unsigned PMT_POST_LSB = 3;
   localparam int unsigned PMT_IRQ_BIT = 1;

   localparam logic [1:0] PMT_PRE_DIV1 = 2'h0;
   localparam logic [1:0] PMT_PRE_DIV4 = 2'h1;
   localparam logic [3:0] PMT_PRE_LAST1 = 4'h0;
   localparam logic [3:0] PMT_PRE_LAST4 = 4'h3;
   localparam logic [3:0] PMT_PRE_LAST16 = 4'hf;
endpackage

// ===== hdl/pmt_timer.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module pmt_timer
   import pmt_pkg::*;
(
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [PMT_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic MATCH_PULSE,
   output logic IRQ
);

   logic [7:0] count_q;
   logic [7:0] period_q;
   logic [6:0] control_q;
   logic [3:0] pre_q;
   logic [3:0] post_q;
   logic flag_q;
   logic enable_q;
   logic match_q;
   logic [31:0] rdata_q;

   logic access;
   logic setup;
   logic wr_count;
   logic wr_period;
   logic wr_control;
   logic wr_enables;
   logic rd_flags;
   logic run;
   logic tick;
   logic equal;
   logic match_now;
   logic post_done;
   logic [1:0] pre_sel;
   logic [3:0] post_sel;

   function automatic logic [3:0] pre_last(input logic [1:0] sel);
      if (sel == PMT_PRE_DIV1) begin
         pre_last = PMT_PRE_LAST1;
      end else if (sel == PMT_PRE_DIV4) begin
         pre_last = PMT_PRE_LAST4;
      end else begin
         pre_last = PMT_PRE_LAST16;
      end
   endfunction

   function automatic logic mapped(input logic [PMT_AW-1:0] a);
      mapped = (a == PMT_OFS_COUNT) || (a == PMT_OFS_PERIOD) || (a == PMT_OFS_CONTROL) ||
               (a == PMT_OFS_FLAGS) || (a == PMT_OFS_ENABLES);
   endfunction

   // zero-wait slave: every access phase completes at once
   assign PREADY = 1'b1;
   assign PSLVERR = access && !mapped(PADDR);
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign wr_count = access && PWRITE && (PADDR == PMT_OFS_COUNT);
   assign wr_period = access && PWRITE && (PADDR == PMT_OFS_PERIOD);
   assign wr_control = access && PWRITE && (PADDR == PMT_OFS_CONTROL);
   assign wr_enables = access && PWRITE && (PADDR == PMT_OFS_ENABLES);
   assign rd_flags = access && !PWRITE && (PADDR == PMT_OFS_FLAGS);

   assign pre_sel = control_q[PMT_PRE_LSB +: 2];
   assign post_sel = control_q[PMT_POST_LSB +: 4];
   assign run = control_q[PMT_RUN_BIT];
   assign tick = run && (pre_q == pre_last(pre_sel));
   assign equal = (count_q == period_q);
   // a count or control write in the same cycle wins over the timer's own step
   assign match_now = tick && equal && !wr_count && !wr_control;
   assign post_done = match_now && (post_q == post_sel);

   assign MATCH_PULSE = match_q;
   assign IRQ = flag_q && enable_q;

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         count_q <= PMT_COUNT_RST;
      end else if (wr_count) begin
         count_q <= PWDATA[7:0];
      end else if (match_now) begin
         count_q <= PMT_COUNT_RST;
      end else if (tick && !wr_control) begin
         count_q <= count_q + 8'h01;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         period_q <= PMT_PERIOD_RST;
      end else if (wr_period) begin
         period_q <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         control_q <= PMT_CONTROL_RST;
      end else if (wr_control) begin
         control_q <= PWDATA[6:0];
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         pre_q <= 4'h0;
      end else if (wr_count || wr_control) begin
         pre_q <= 4'h0;
      end else if (tick) begin
         pre_q <= 4'h0;
      end else if (run) begin
         pre_q <= pre_q + 4'h1;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         post_q <= 4'h0;
      end else if (wr_count || wr_control) begin
         post_q <= 4'h0;
      end else if (post_done) begin
         post_q <= 4'h0;
      end else if (match_now) begin
         post_q <= post_q + 4'h1;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match_now;
      end
   end

   // set beats the read-clear so an event landing on the read is kept
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         flag_q <= 1'b0;
      end else if (post_done) begin
         flag_q <= 1'b1;
      end else if (rd_flags) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         enable_q <= 1'b0;
      end else if (wr_enables) begin
         enable_q <= PWDATA[PMT_IRQ_BIT];
      end
   end

   // read data captured in the setup cycle; an event landing there is reported
   // too, since the access edge that follows clears the flag
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_q <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         rdata_q <= 32'h0000_0000;
         unique case (PADDR)
            PMT_OFS_COUNT: rdata_q[7:0] <= count_q;
            PMT_OFS_PERIOD: rdata_q[7:0] <= period_q;
            PMT_OFS_CONTROL: rdata_q[6:0] <= control_q;
            PMT_OFS_FLAGS: rdata_q[PMT_IRQ_BIT] <= flag_q || post_done;
            PMT_OFS_ENABLES: rdata_q[PMT_IRQ_BIT] <= enable_q;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign PRDATA = rdata_q;

   // checker-only: run cycles since the last clean prescaler tick
   logic [4:0] tick_gap_q;
   logic tick_clean_q;
   // checker-only: matches since the last clean postscale event
   logic [4:0] match_seen_q;
   logic post_clean_q;

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_gap_q <= 5'h00;
      end else if (tick) begin
         tick_gap_q <= 5'h00;
      end else if (run) begin
         tick_gap_q <= tick_gap_q + 5'h01;
      end
   end

   // a count or control write restarts both scalers, so the span it cuts is not judged
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_clean_q <= 1'b0;
      end else if (wr_count || wr_control) begin
         tick_clean_q <= 1'b0;
      end else if (tick) begin
         tick_clean_q <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         match_seen_q <= 5'h00;
      end else if (post_done) begin
         match_seen_q <= 5'h00;
      end else if (match_now) begin
         match_seen_q <= match_seen_q + 5'h01;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         post_clean_q <= 1'b0;
      end else if (wr_count || wr_control) begin
         post_clean_q <= 1'b0;
      end else if (post_done) begin
         post_clean_q <= 1'b1;
      end
   end

   AST_CNT_STEP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      tick && !equal && !wr_count && !wr_control |=> count_q == $past(count_q) + 8'h01)
      else $error("count did not step on tick");

   AST_PRE_DIV4: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      tick && tick_clean_q && pre_sel == PMT_PRE_DIV4 |-> tick_gap_q == 5'(PMT_PRE_LAST4))
      else $error("divide by four tick at wrong spacing");

   AST_PRE_DIV16: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      tick && tick_clean_q && pre_sel[1] |-> tick_gap_q == 5'(PMT_PRE_LAST16))
      else $error("divide by sixteen tick at wrong spacing");

   AST_PRE_DIV1: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      run && tick_clean_q && pre_sel == PMT_PRE_DIV1 |-> tick)
      else $error("undivided prescaler skipped a cycle");

   AST_MATCH_CAUSE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      MATCH_PULSE |-> $past(count_q == period_q) && $past(run))
      else $error("match pulse without equal count");

   AST_MATCH_CLEAR: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      MATCH_PULSE |-> count_q == 8'h00)
      else $error("count not cleared after match");

   AST_WRITE_CLEARS: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wr_count || wr_control |=> pre_q == 4'h0 && post_q == 4'h0)
      else $error("scalers not cleared by write");

   AST_CTRL_KEEPS: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wr_control && !wr_count |=> count_q == $past(count_q))
      else $error("control write changed count");

   AST_FLAG_SET: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      match_now && post_q == post_sel |=> flag_q && post_q == 4'h0)
      else $error("flag not set at postscale end");

   AST_IRQ_GATE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      post_done && enable_q && !wr_enables |=> IRQ)
      else $error("enabled match event raised no interrupt");

   AST_STOP_HOLD: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      !run && !wr_count && !wr_control |=> $stable(count_q) && $stable(pre_q) &&
      $stable(post_q) && !MATCH_PULSE)
      else $error("stopped timer moved");

   AST_BIT7_ZERO: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      access && !PWRITE && PADDR == PMT_OFS_CONTROL |-> PRDATA[7] == 1'b0)
      else $error("control bit 7 read nonzero");

   AST_POST_RATIO: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      match_now && post_clean_q |-> post_done == (match_seen_q == 5'(post_sel)))
      else $error("postscale event at wrong match count");

   AST_FLAG_HOLD: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      flag_q && !rd_flags |=> flag_q)
      else $error("match flag dropped without a read");

   AST_FLAG_SEEN: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      setup && !PWRITE && PADDR == PMT_OFS_FLAGS && (flag_q || post_done)
      |=> PRDATA[PMT_IRQ_BIT])
      else $error("flag read missed a pending event");

   AST_COUNT_WRITE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wr_count |=> count_q == $past(PWDATA[7:0]))
      else $error("count write not stored");

   AST_PERIOD_WRITE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wr_period |=> period_q == $past(PWDATA[7:0]))
      else $error("period write not stored");

   AST_ENABLE_WRITE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wr_enables |=> enable_q == $past(PWDATA[PMT_IRQ_BIT]))
      else $error("enable write not stored");

   COV_MATCH: cover property (@(posedge CLOCK) disable iff (!ARST_N) MATCH_PULSE);
   COV_IRQ: cover property (@(posedge CLOCK) disable iff (!ARST_N) $rose(IRQ));
   COV_SET_ON_CLEAR: cover property (@(posedge CLOCK) disable iff (!ARST_N)
      post_done && rd_flags);
   COV_DIV16_MATCH: cover property (@(posedge CLOCK) disable iff (!ARST_N)
      match_now && pre_sel[1] && post_sel != 4'h0);
   COV_CLEAN_DIV4: cover property (@(posedge CLOCK) disable iff (!ARST_N)
      tick && tick_clean_q && pre_sel == PMT_PRE_DIV4);

endmodule // pmt_timer

// ===== bench/period_match_timer8_tb.sv
`timescale 1ns/1ps
module period_match_timer8_tb;
   import pmt_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PMT_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic match_pulse;
   logic irq;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int check_count = 0;
   int k;
   int m;
   int ns[3] = '{0, 3, 15};

   always #4 clock = ~clock;

   pmt_timer i_pmt_timer (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .MATCH_PULSE(match_pulse), .IRQ(irq));

   task automatic report_and_stop();
      if (mismatches == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // request held until pready is sampled high; data taken at that edge
   task automatic apb(input logic w, input logic [PMT_AW-1:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [PMT_AW-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string what, input logic [PMT_AW-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(what, rd, e);
   endtask

   // cycles between two successive match pulses
   task automatic gap();
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (match_pulse !== 1'b1 && k < 400);
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (match_pulse !== 1'b1 && k < 400);
   endtask

   initial begin
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      rdchk("count", PMT_OFS_COUNT, 32'h0);
      rdchk("period", PMT_OFS_PERIOD, 32'hff);
      rdchk("control", PMT_OFS_CONTROL, 32'h0);
      rdchk("flags", PMT_OFS_FLAGS, 32'h0);
      wr(PMT_OFS_PERIOD, 32'ha5);
      rdchk("period", PMT_OFS_PERIOD, 32'ha5);
      wr(PMT_OFS_PERIOD, 32'h2);
      for (int c = 0; c < 4; c++) begin
         wr(PMT_OFS_CONTROL, 32'h4 | c);
         gap();
         check("interval", 32'(k), 3 * ((c == 0) ? 1 : (c == 1) ? 4 : 16));
      end
      wr(PMT_OFS_PERIOD, 32'h1);
      wr(PMT_OFS_ENABLES, 32'h2);
      rdchk("enables", PMT_OFS_ENABLES, 32'h2);
      foreach (ns[i]) begin
         wr(PMT_OFS_CONTROL, 32'h0);
         wr(PMT_OFS_COUNT, 32'h0);
         apb(1'b0, PMT_OFS_FLAGS, 32'h0);
         wr(PMT_OFS_CONTROL, (32'(ns[i]) << 3) | 32'h4);
         m = 0;
         k = 0;
         do begin
            @(posedge clock);
            k++;
            if (match_pulse === 1'b1) m++;
         end while (irq !== 1'b1 && k < 100);
         check("matches per irq", 32'(m), 32'(ns[i] + 1));
         wr(PMT_OFS_CONTROL, 32'h0);
         rdchk("flags", PMT_OFS_FLAGS, 32'h2);
         @(posedge clock);
         check("irq after clear", {31'h0, irq}, 32'h0);
      end
      // masked: flag still latches but no request
      wr(PMT_OFS_ENABLES, 32'h0);
      wr(PMT_OFS_CONTROL, 32'h4);
      m = 0;
      repeat (20) begin
         @(posedge clock);
         if (irq !== 1'b0) m++;
      end
      check("masked irq", 32'(m), 32'h0);
      wr(PMT_OFS_CONTROL, 32'h0);
      rdchk("flags", PMT_OFS_FLAGS, 32'h2);
      rdchk("flags", PMT_OFS_FLAGS, 32'h0);
      wr(PMT_OFS_COUNT, 32'h5);
      rdchk("count", PMT_OFS_COUNT, 32'h5);
      m = 0;
      repeat (40) begin
         @(posedge clock);
         if (match_pulse !== 1'b0) m++;
      end
      check("stopped pulses", 32'(m), 32'h0);
      rdchk("count", PMT_OFS_COUNT, 32'h5);
      wr(PMT_OFS_CONTROL, 32'hfb);
      rdchk("control", PMT_OFS_CONTROL, 32'h7b);
      rdchk("count", PMT_OFS_COUNT, 32'h5);
      // reset in mid-run while the timer counts
      wr(PMT_OFS_CONTROL, 32'h4);
      repeat (5) @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      rdchk("count", PMT_OFS_COUNT, 32'h0);
      rdchk("period", PMT_OFS_PERIOD, 32'hff);
      rdchk("control", PMT_OFS_CONTROL, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      report_and_stop();
   end

   initial begin
      #240000;
      mismatches++;
      report_and_stop();
   end
endmodule // period_match_timer8_tb
